// ==== rtl/sfc_consts.svh ====
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
`define SFC_OP_WREN       8'h06
`define SFC_OP_WRDI       8'h04
`define SFC_OP_RDSR1      8'h05
`define SFC_OP_RDSR2      8'h35
`define SFC_OP_RDSR3      8'h15
`define SFC_OP_VWREN      8'h50
`define SFC_OP_WRSR1      8'h01
`define SFC_OP_WRSR2      8'h31
`define SFC_OP_WRSR3      8'h11
`define SFC_OP_READ       8'h03
`define SFC_OP_FREAD      8'h0b
`define SFC_OP_DREAD      8'h3b
`define SFC_OP_DIOREAD    8'hbb
`define SFC_OP_QREAD      8'h6b
`define SFC_OP_QIOREAD    8'heb
`define SFC_OP_QWREAD     8'he7
`define SFC_OP_PP         8'h02
`define SFC_OP_QPP        8'h32
`define SFC_OP_FPP        8'hf2
`define SFC_OP_SE         8'h20
`define SFC_OP_BE32       8'h52
`define SFC_OP_BE64       8'hd8
`define SFC_OP_CE1        8'hc7
`define SFC_OP_CE2        8'h60
`define SFC_OP_RSTEN      8'h66
`define SFC_OP_RST        8'h99
`define SFC_OP_DPD        8'hb9
`define SFC_OP_RDPD       8'hab
`define SFC_OP_MDID       8'h90
`define SFC_OP_MDID2      8'h92
`define SFC_OP_MDID4      8'h94
`define SFC_OP_JEDEC      8'h9f
`define SFC_OP_PARAM      8'h5a
`define SFC_OP_SECER      8'h44
`define SFC_OP_SECPG      8'h42
`define SFC_OP_SECRD      8'h48
// Status bit positions within the 24-bit status word
`define SFC_SR_BUSY       0
`define SFC_SR_WEL        1
`define SFC_SR_BP_LSB     2
`define SFC_SR_PROT_LO    7
`define SFC_SR_PROT_HI    8
`define SFC_SR_INV        14
`define SFC_SR1_WMASK     8'hfc
`define SFC_SR2_WMASK     8'h7f
`define SFC_SR3_WMASK     8'h60
`define SFC_SR_RESET      24'h000200
`define SFC_ADDR_BITS     24
`define SFC_BUSY_NS       1000
`define SFC_BUSY_CYC      ((`SFC_BUSY_NS + 24) / 25)
`endif

// ==== rtl/sfc_pkg.sv ====
package sfc_pkg;
	typedef enum logic [4:0] {
		SFC_CMD_NONE  = 5'h01,
		SFC_CMD_WRITE = 5'h02,
		SFC_CMD_ERASE = 5'h04,
		SFC_CMD_WRSR  = 5'h08,
		SFC_CMD_OTHER = 5'h10
	} sfc_job_t;
endpackage : sfc_pkg

// ==== rtl/sfc_flash_cmd.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sfc_consts.svh"
module sfc_flash_cmd #(
	parameter int MAKER_ID   = 8'h5a,  // Arbitrary value
	parameter int DEV_ID_HI  = 8'h3c,  // Arbitrary value
	parameter int DEV_ID_LO  = 8'h0e,  // Arbitrary value
	parameter int DEV_ID_SH  = 8'h33,  // Arbitrary value
	parameter int BUSY_CYC   = `SFC_BUSY_CYC
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      spi_clk,
	input  wire logic                      cs_n,
	input  wire logic                      spi_si,
	input  wire logic                      write_protect_pin_n,
	output var  logic                      spi_so,
	output var  logic                      spi_so_oe_n,
	output var  logic [23:0]               status_word,
	output var  logic                      deep_pd,
	output var  logic                      array_req,
	output var  sfc_pkg::sfc_job_t         array_job,
	output var  logic [23:0]               array_addr,
	output var  logic [7:0]                array_opcode,
	output var  logic                      array_refused,
	input  wire logic [7:0]                array_rdata
);
	initial begin
		if (BUSY_CYC < 1 || MAKER_ID > 255 || DEV_ID_HI > 255 || DEV_ID_LO > 255 || DEV_ID_SH > 255)
			$error("sfc_flash_cmd: bad parameter");
	end

	function automatic logic is_modify(input logic [7:0] op);
		case (op)
			`SFC_OP_WREN, `SFC_OP_WRDI, `SFC_OP_WRSR1, `SFC_OP_WRSR2, `SFC_OP_WRSR3,
			`SFC_OP_PP, `SFC_OP_QPP, `SFC_OP_FPP, `SFC_OP_SE, `SFC_OP_BE32, `SFC_OP_BE64,
			`SFC_OP_CE1, `SFC_OP_CE2, `SFC_OP_DPD, `SFC_OP_SECER, `SFC_OP_SECPG,
			`SFC_OP_VWREN, `SFC_OP_RST: is_modify = 1'b1;
			default: is_modify = 1'b0;
		endcase
	endfunction : is_modify

	function automatic logic is_prog(input logic [7:0] op);
		is_prog = (op == `SFC_OP_PP) || (op == `SFC_OP_QPP) || (op == `SFC_OP_FPP) || (op == `SFC_OP_SECPG);
	endfunction : is_prog

	function automatic logic is_erase(input logic [7:0] op);
		is_erase = (op == `SFC_OP_SE) || (op == `SFC_OP_BE32) || (op == `SFC_OP_BE64) ||
			(op == `SFC_OP_CE1) || (op == `SFC_OP_CE2) || (op == `SFC_OP_SECER);
	endfunction : is_erase

	// Region check: lo/hi bounds of protected window, then optional complement
	function automatic logic in_prot(input logic [23:0] a, input logic [4:0] bp, input logic inv);
		logic [23:0] size;
		logic        bot;
		logic        hit;
		size = 24'h000000;
		bot  = bp[3];
		if (bp[2:0] == 3'h7)
			size = 24'hffffff;
		else if (bp[2:0] == 3'h0)
			size = 24'h000000;
		else if (!bp[4])
			size = 24'(24'h040000 << (bp[2:0] - 3'h1)) - 24'h000001;
		else if (bp[2:0] >= 3'h4)
			size = 24'h007fff;
		else
			size = 24'(24'h001000 << (bp[2:0] - 3'h1)) - 24'h000001;
		if (bp[2:0] == 3'h0)
			hit = 1'b0;
		else if (bp[2:0] == 3'h7)
			hit = 1'b1;
		else if (bot)
			hit = (a <= size);
		else
			hit = (a >= ~size);
		in_prot = hit ^ inv;
	endfunction : in_prot

	// ---------------- Link domain ----------------
	// Async clear by cs_n is avoided; frame start is detected from the first edge's cs state
	logic [7:0]  sh_ff;
	logic [15:0] bitcnt_ff;
	logic [7:0]  op_ff;
	logic [23:0] addr_ff;
	logic        sel_ff;
	logic [7:0]  last_byte_ff;
	// Toggle starts at a known level; the link side has no reset of its own
	logic        byte_tog_ff = 1'b0;
	logic [7:0]  osh_ff;
	logic [23:0] sr_l_ff;
	logic        dpd_l_ff;
	logic [7:0]  rdat_l_ff;

	wire  [7:0]  nxt_sh    = {sh_ff[6:0], spi_si};
	wire  [15:0] nxt_cnt   = bitcnt_ff + 16'h0001;

	// Frame counter resets when cs is high at the clock edge (host gives one lead-in edge then)
	always_ff @(posedge spi_clk) begin
		sel_ff <= ~cs_n;
		if (cs_n || !sel_ff)
			bitcnt_ff <= cs_n ? 16'h0000 : 16'h0001;
		else
			bitcnt_ff <= nxt_cnt;
	end

	always_ff @(posedge spi_clk) begin
		if (!cs_n) begin
			sh_ff <= (cs_n || !sel_ff) ? {7'h00, spi_si} : nxt_sh;
			if ((sel_ff ? nxt_cnt[2:0] : 3'h1) == 3'h0) begin
				last_byte_ff <= nxt_sh;
				byte_tog_ff  <= ~byte_tog_ff;
				if (nxt_cnt == 16'h0008)
					op_ff <= nxt_sh;
				else if (nxt_cnt <= 16'h0020)
					addr_ff <= {addr_ff[15:0], nxt_sh};
			end
		end
	end

	// Byte index (count of whole bytes completed)
	wire [12:0] byte_idx = bitcnt_ff[15:3];

	// Output data selection for the byte now being sent
	logic [7:0] out_byte;
	always_comb begin
		out_byte = 8'h00;
		case (op_ff)
			`SFC_OP_RDSR1: out_byte = sr_l_ff[7:0];
			`SFC_OP_RDSR2: out_byte = sr_l_ff[15:8];
			`SFC_OP_RDSR3: out_byte = sr_l_ff[23:16];
			`SFC_OP_JEDEC: out_byte = (byte_idx == 13'h1) ? 8'(MAKER_ID) :
				(byte_idx == 13'h2) ? 8'(DEV_ID_HI) : 8'(DEV_ID_LO);
			`SFC_OP_MDID, `SFC_OP_MDID2, `SFC_OP_MDID4:
				out_byte = byte_idx[0] ? 8'(DEV_ID_SH) : 8'(MAKER_ID);
			`SFC_OP_RDPD: out_byte = 8'(DEV_ID_SH);
			default: out_byte = rdat_l_ff;
		endcase
	end

	function automatic logic [12:0] data_start(input logic [7:0] op);
		case (op)
			`SFC_OP_RDSR1, `SFC_OP_RDSR2, `SFC_OP_RDSR3, `SFC_OP_JEDEC: data_start = 13'h1;
			`SFC_OP_READ: data_start = 13'h4;
			`SFC_OP_MDID, `SFC_OP_MDID2, `SFC_OP_MDID4, `SFC_OP_RDPD: data_start = 13'h4;
			`SFC_OP_FREAD, `SFC_OP_DREAD, `SFC_OP_QREAD, `SFC_OP_DIOREAD, `SFC_OP_QIOREAD,
			`SFC_OP_QWREAD, `SFC_OP_PARAM, `SFC_OP_SECRD: data_start = 13'h5;
			default: data_start = 13'h1fff;
		endcase
	endfunction : data_start

	// Data shifted out on falling edges; output enable dropped as soon as cs rises
	always_ff @(negedge spi_clk) begin
		if (bitcnt_ff[2:0] == 3'h0 && byte_idx >= data_start(op_ff) && !dpd_l_ff) begin
			osh_ff   <= {out_byte[6:0], 1'b0};
			spi_so   <= out_byte[7];
		end else begin
			osh_ff <= {osh_ff[6:0], 1'b0};
			spi_so <= osh_ff[7];
		end
	end

	assign spi_so_oe_n = cs_n || (byte_idx < data_start(op_ff)) || (dpd_l_ff && op_ff != `SFC_OP_RDPD);

	// Status and read data cross into the link domain through two stages
	logic [23:0] sr_s1_ff;
	logic        dpd_s1_ff;
	logic [7:0]  rd_s1_ff;
	always_ff @(posedge spi_clk) begin
		sr_s1_ff  <= status_word;
		sr_l_ff   <= sr_s1_ff;
		dpd_s1_ff <= deep_pd;
		dpd_l_ff  <= dpd_s1_ff;
		rd_s1_ff  <= array_rdata;
		rdat_l_ff <= rd_s1_ff;
	end

	// ---------------- System domain ----------------
	logic [2:0]  cs_sync_ff;
	logic [2:0]  tog_sync_ff;
	logic [1:0]  wp_sync_ff;
	logic [15:0] cnt_at_end;
	logic [7:0]  op_s_ff;
	logic [23:0] addr_s_ff;
	logic [7:0]  data_s_ff;
	logic [3:0]  nbytes_ff;
	logic        data_seen_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cs_sync_ff  <= 3'h7;
			tog_sync_ff <= 3'h0;
			wp_sync_ff  <= 2'h3;
		end else begin
			cs_sync_ff  <= {cs_sync_ff[1:0], cs_n};
			tog_sync_ff <= {tog_sync_ff[1:0], byte_tog_ff};
			wp_sync_ff  <= {wp_sync_ff[0], write_protect_pin_n};
		end
	end

	wire frame_end  = cs_sync_ff[1] && !cs_sync_ff[2];
	wire frame_beg  = !cs_sync_ff[1] && cs_sync_ff[2];
	wire byte_event = tog_sync_ff[1] ^ tog_sync_ff[2];
	// Link registers are stable once cs is high, so they are read after the synchronised rise
	assign cnt_at_end = bitcnt_ff;

	always_ff @(posedge ref_clk) begin
		if (rst || frame_beg) begin
			nbytes_ff    <= 4'h0;
			data_seen_ff <= 1'b0;
		end else if (byte_event) begin
			if (nbytes_ff != 4'hf)
				nbytes_ff <= nbytes_ff + 4'h1;
			if (nbytes_ff == 4'h0)
				op_s_ff <= last_byte_ff;
			else if (nbytes_ff <= 4'h3)
				addr_s_ff <= {addr_s_ff[15:0], last_byte_ff};
			if (nbytes_ff == 4'h1)
				data_s_ff <= last_byte_ff;
			if (nbytes_ff >= 4'h4)
				data_seen_ff <= 1'b1;
		end
	end

	// Status word and control
	logic [23:0] sr_ff;
	logic        dpd_ff;
	logic        vwen_ff;
	logic        rst_arm_ff;
	logic [15:0] busy_cnt_ff;
	sfc_pkg::sfc_job_t job_ff;

	wire aligned   = (cnt_at_end[2:0] == 3'h0);
	wire write_latch_flag       = sr_ff[`SFC_SR_WEL];
	wire busy      = sr_ff[`SFC_SR_BUSY];
	wire prot_hi   = sr_ff[`SFC_SR_PROT_HI];
	wire prot_lo   = sr_ff[`SFC_SR_PROT_LO];
	wire [4:0] bp  = sr_ff[`SFC_SR_BP_LSB +: 5];
	wire inv       = sr_ff[`SFC_SR_INV];
	// Status writes allowed only in software or hardware-unprotected mode
	wire sr_lock   = (prot_hi) || (prot_lo && !wp_sync_ff[1]);
	wire is_wrsr   = (op_s_ff == `SFC_OP_WRSR1) || (op_s_ff == `SFC_OP_WRSR2) || (op_s_ff == `SFC_OP_WRSR3);
	wire chip_er   = (op_s_ff == `SFC_OP_CE1) || (op_s_ff == `SFC_OP_CE2);
	wire chip_ok   = inv ? (bp[2:0] == 3'h7) : (bp[2:0] == 3'h0);
	wire tgt_prot  = chip_er ? !chip_ok : in_prot(addr_s_ff, bp, inv);
	wire valid_end = frame_end && !busy;
	// Deep power-down accepts only the release opcode
	wire live      = valid_end && (!dpd_ff || op_s_ff == `SFC_OP_RDPD);
	wire mod_ok    = live && (!is_modify(op_s_ff) || aligned);
	wire wr_len_ok = is_wrsr ? (nbytes_ff == 4'h2) : 1'b1;
	wire addr_ok   = chip_er ? (nbytes_ff == 4'h1) : (nbytes_ff >= 4'h4);
	wire do_prog   = mod_ok && write_latch_flag && is_prog(op_s_ff) && data_seen_ff;
	wire do_erase  = mod_ok && write_latch_flag && is_erase(op_s_ff) && addr_ok;
	wire do_wrsr   = mod_ok && (write_latch_flag || vwen_ff) && is_wrsr && wr_len_ok && !sr_lock;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sr_ff <= `SFC_SR_RESET;
		end else begin
			if (busy_cnt_ff == 16'h0001) begin
				sr_ff[`SFC_SR_BUSY] <= 1'b0;
				sr_ff[`SFC_SR_WEL]  <= 1'b0;
			end
			if (mod_ok && op_s_ff == `SFC_OP_WREN)
				sr_ff[`SFC_SR_WEL] <= 1'b1;
			if (mod_ok && op_s_ff == `SFC_OP_WRDI)
				sr_ff[`SFC_SR_WEL] <= 1'b0;
			if (mod_ok && rst_arm_ff && op_s_ff == `SFC_OP_RST)
				sr_ff <= `SFC_SR_RESET;
			if (do_wrsr) begin
				sr_ff[`SFC_SR_BUSY] <= 1'b1;
				case (op_s_ff)
					`SFC_OP_WRSR1: sr_ff[7:0] <= (data_s_ff & `SFC_SR1_WMASK) | (sr_ff[7:0] & ~`SFC_SR1_WMASK);
					`SFC_OP_WRSR2: sr_ff[15:8] <= (data_s_ff & `SFC_SR2_WMASK) | (sr_ff[15:8] & ~`SFC_SR2_WMASK);
					default: sr_ff[23:16] <= (data_s_ff & `SFC_SR3_WMASK) | (sr_ff[23:16] & ~`SFC_SR3_WMASK);
				endcase
			end
			if (do_prog || do_erase) begin
				sr_ff[`SFC_SR_BUSY] <= 1'b1;
				if (tgt_prot)
					sr_ff[`SFC_SR_WEL] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			busy_cnt_ff <= 16'h0000;
		else if (do_wrsr || ((do_prog || do_erase) && !tgt_prot))
			busy_cnt_ff <= 16'(BUSY_CYC);
		else if (do_prog || do_erase)
			busy_cnt_ff <= 16'h0001;
		else if (busy_cnt_ff != 16'h0000)
			busy_cnt_ff <= busy_cnt_ff - 16'h0001;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dpd_ff     <= 1'b0;
			vwen_ff    <= 1'b0;
			rst_arm_ff <= 1'b0;
		end else if (live) begin
			if (mod_ok && op_s_ff == `SFC_OP_DPD)
				dpd_ff <= 1'b1;
			else if (op_s_ff == `SFC_OP_RDPD)
				dpd_ff <= 1'b0;
			vwen_ff    <= mod_ok && (op_s_ff == `SFC_OP_VWREN);
			rst_arm_ff <= mod_ok && (op_s_ff == `SFC_OP_RSTEN);
		end
	end

	// Array request issued only for unprotected program or erase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			array_req     <= 1'b0;
			array_refused <= 1'b0;
			job_ff        <= sfc_pkg::SFC_CMD_NONE;
			array_addr    <= 24'h000000;
			array_opcode  <= 8'h00;
		end else begin
			array_req     <= (do_prog || do_erase) && !tgt_prot;
			array_refused <= (do_prog || do_erase) && tgt_prot;
			if (do_prog || do_erase) begin
				job_ff       <= do_prog ? sfc_pkg::SFC_CMD_WRITE : sfc_pkg::SFC_CMD_ERASE;
				array_addr   <= addr_s_ff;
				array_opcode <= op_s_ff;
			end
		end
	end

	assign array_job   = job_ff;
	assign status_word = sr_ff;
	assign deep_pd     = dpd_ff;
endmodule : sfc_flash_cmd
`default_nettype wire

// ==== testbench/sfc_spi_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfc_spi_host (
	output var  logic spi_clk,
	output var  logic cs_n,
	output var  logic spi_si,
	input  wire logic spi_so
);
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// Clock stands still between frames; one lead-in edge with cs_n high re-arms the link side
	task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
		rx = '0;
		#40 spi_clk = 1'b1;
		#40 spi_clk = 1'b0;
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			spi_si = tx[i];
			#40 rx = {rx[62:0], spi_so};
			spi_clk = 1'b1;
			#40 spi_clk = 1'b0;
		end
		#40 cs_n = 1'b1;
		spi_si = ~spi_si;
		#400;
	endtask : frame
endmodule : sfc_spi_host
`default_nettype wire

// ==== testbench/sfc_flash_cmd_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfc_flash_cmd_chk #(parameter int BUSY_CYC = 4) (
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire logic              cs_n,
	input wire logic              write_protect_pin_n,
	input wire logic              spi_so_oe_n,
	input wire logic [23:0]       status_word,
	input wire logic              deep_pd,
	input wire logic              array_req,
	input wire sfc_pkg::sfc_job_t array_job,
	input wire logic              array_refused
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Write latch drops when the busy count ends, on the same edge as its last step
	localparam int LATCH_MAX = BUSY_CYC + 1;
	int unsigned busy_run_ff;
	always_ff @(posedge ref_clk) begin
		if (rst || !status_word[0])
			busy_run_ff <= 0;
		else
			busy_run_ff <= busy_run_ff + 1;
	end
	sequence busy_soon; ##[0:3] status_word[0]; endsequence
	sequence latch_gone; ##[0:LATCH_MAX] !status_word[1]; endsequence
	req_busy_a: assert property (array_req |-> busy_soon)
		else $error("busy missing after array request");
	busy_len_a: assert property (busy_run_ff <= BUSY_CYC + 2)
		else $error("busy held too long");
	req_latch_a: assert property (array_req |-> latch_gone)
		else $error("write latch kept after array request");
	ref_latch_a: assert property (array_refused |-> latch_gone)
		else $error("write latch kept after refusal");
	req_excl_a: assert property (!(array_req && array_refused))
		else $error("request and refusal together");
	req_job_a: assert property (array_req |-> array_job inside {sfc_pkg::SFC_CMD_WRITE, sfc_pkg::SFC_CMD_ERASE})
		else $error("bad job on array request");
	req_framed_a: assert property (array_req |-> cs_n && $past(cs_n))
		else $error("array request inside a frame");
	oe_framed_a: assert property (!spi_so_oe_n |-> !cs_n)
		else $error("output driven while deselected");
	pd_ignore_a: assert property (deep_pd && $past(deep_pd) |-> !array_req && $stable(status_word[23:1]))
		else $error("command honoured in power-down");
	sr_lockdown_a: assert property (status_word[8:7] == 2'b10 |=> $stable(status_word[14:2]))
		else $error("status changed in lock-down");
	hw_lock_a: assert property (status_word[8:7] == 2'b01 && !write_protect_pin_n |=> $stable(status_word[14:2]))
		else $error("status changed under pin lock");
endmodule : sfc_flash_cmd_chk
bind sfc_flash_cmd sfc_flash_cmd_chk #(.BUSY_CYC(BUSY_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
	.write_protect_pin_n(write_protect_pin_n), .spi_so_oe_n(spi_so_oe_n), .status_word(status_word),
	.deep_pd(deep_pd), .array_req(array_req), .array_job(array_job), .array_refused(array_refused));
`default_nettype wire

// ==== testbench/serial_flash_command_and_protection_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_flash_command_and_protection_tb;
	localparam logic [7:0] MID = 8'h5a; // Arbitrary value
	localparam logic [7:0] DHI = 8'h3c; // Arbitrary value
	localparam logic [7:0] DLO = 8'h0e; // Arbitrary value
	localparam logic [7:0] DSH = 8'h33; // Arbitrary value
	localparam logic [7:0] RDAT = 8'ha5;
	logic              ref_clk, rst, wp_n, spi_clk, cs_n, spi_si, spi_so, spi_so_oe_n, so_w;
	logic              deep_pd, array_req, array_refused;
	logic [23:0]       status_word, array_addr, req_addr;
	logic [7:0]        array_opcode, req_op;
	sfc_pkg::sfc_job_t array_job, req_job;
	logic [63:0]       rx;
	logic [31:0]       e;
	logic [55:0]       o;
	int                fails, cmp_count, n_req, n_ref, q0, r0;
	logic [31:0] prot_tbl [16] = '{32'h05fc0000, 32'h04fbf000, 32'h2503f000, 32'h24040000, 32'h45fff000,
		32'h44ffe000, 32'h6d003000, 32'h6c004000, 32'h51ff8000, 32'h50ff7000, 32'h1d000000, 32'h00fff000,
		32'h84fc0000, 32'h85fbf000, 32'he4000000, 32'he5001000};
	logic [55:0] ops [6] = '{{8'h20, 8'd32, 40'h0020000100}, {8'h52, 8'd32, 40'h0052000100},
		{8'hd8, 8'd32, 40'h00d8000100}, {8'hc7, 8'd8, 40'h00000000c7}, {8'h60, 8'd8, 40'h0000000060},
		{8'h02, 8'd40, 40'h020001003c}};
	// Released output line follows spi_clk, which is low at every host sample, so it always reads as 0
	assign so_w = spi_so_oe_n ? spi_clk : spi_so;
	sfc_flash_cmd #(.MAKER_ID(MID), .DEV_ID_HI(DHI), .DEV_ID_LO(DLO), .DEV_ID_SH(DSH), .BUSY_CYC(4)) DUT (
		.ref_clk(ref_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n), .spi_si(spi_si),
		.write_protect_pin_n(wp_n), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .status_word(status_word),
		.deep_pd(deep_pd), .array_req(array_req), .array_job(array_job), .array_addr(array_addr),
		.array_opcode(array_opcode), .array_refused(array_refused), .array_rdata(RDAT));
	sfc_spi_host host (.spi_clk(spi_clk), .cs_n(cs_n), .spi_si(spi_si), .spi_so(so_w));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (array_req === 1'b1) begin
			n_req++;
			req_addr = array_addr;
			req_op = array_opcode;
			req_job = array_job;
		end
		if (array_refused === 1'b1)
			n_ref++;
	end
	task automatic chk(input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	task automatic cmd(input logic [63:0] tx, input int n);
		@(posedge ref_clk);
		#2 host.frame(tx, n, rx);
	endtask : cmd
	task automatic wr_sr(input logic [7:0] op, input logic [7:0] v);
		cmd(64'h06, 8);
		cmd({op, v}, 16);
	endtask : wr_sr
	task automatic end_sim;
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	initial begin
		#1ms;
		fails++;
		end_sim();
	end
	initial begin
		rst = 1'b1;
		wp_n = 1'b1;
		repeat (16) @(posedge ref_clk);
		#2 rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(24'h000200, status_word);
		cmd(64'h06, 8);
		cmd(64'h050000, 24);
		chk(24'h000202, {8'h00, rx[15:0]});
		cmd(64'h350000, 24);
		chk(24'h000202, {8'h00, rx[15:0]});
		cmd(64'h050, 12);
		chk(24'h000001, {23'h0, spi_so_oe_n});
		cmd(64'h020001003, 36);
		chk(24'h000002, {22'h0, status_word[1], 1'b0} | 24'(n_req));
		cmd(64'h04, 8);
		cmd(64'h00c, 9);
		chk(24'h000000, {23'h0, status_word[1]});
		cmd(64'h50, 8);
		cmd(64'h0104, 16);
		chk(24'h000004, {16'h0, status_word[7:2], 2'b00});
		foreach (prot_tbl[i]) begin
			e = prot_tbl[i];
			wr_sr(8'h01, {1'b0, e[30:26], 2'b00});
			wr_sr(8'h31, {1'b0, e[31], 4'h0, 1'b1, 1'b0});
			chk({11'h0, e[31], 4'h0, 1'b1, 2'b00, e[30:26]}, {11'h0, status_word[14:2]});
			q0 = n_req;
			r0 = n_ref;
			cmd(64'h06, 8);
			cmd({8'h20, e[23:0]}, 32);
			chk({e[24], !e[24]}, {24'(n_ref - r0)} << 1 | 24'(n_req - q0));
		end
		wr_sr(8'h01, 8'h00);
		wr_sr(8'h31, 8'h02);
		foreach (ops[i]) begin
			o = ops[i];
			q0 = n_req;
			cmd(64'h06, 8);
			cmd({24'h0, o[39:0]}, int'(o[47:40]));
			chk({15'h0, o[55:48], 1'b1}, {15'h0, req_op, 1'(n_req - q0)});
			chk({o[55:48] == 8'h02 ? sfc_pkg::SFC_CMD_WRITE : sfc_pkg::SFC_CMD_ERASE}, {19'h0, req_job});
			if (o[47:40] > 8'd8)
				chk(24'h000100, req_addr);
		end
		cmd(64'h030000100000, 48);
		chk({8'h00, RDAT, RDAT}, {8'h00, rx[15:0]});
		foreach (ops[i]) begin
			if (i < 3) begin
				cmd({i == 0 ? 8'h0b : i == 1 ? 8'h5a : 8'h48, 48'h0}, 56);
				chk({8'h00, RDAT, RDAT}, {8'h00, rx[15:0]});
			end
		end
		cmd(64'h9f000000, 32);
		chk({MID, DHI, DLO}, rx[23:0]);
		cmd(64'h900000000000, 48);
		chk({8'h00, MID, DSH}, {8'h00, rx[15:0]});
		cmd(64'hb9, 8);
		cmd(64'h06, 8);
		chk(24'h000001, {22'h0, status_word[1], deep_pd});
		cmd(64'hab, 8);
		cmd(64'hab0000000000, 48);
		chk({7'h00, deep_pd, DSH, DSH}, {8'h00, rx[15:0]});
		wr_sr(8'h01, 8'h80);
		@(posedge ref_clk);
		#2 wp_n = 1'b0;
		wr_sr(8'h01, 8'h84);
		chk(24'h000080, {16'h0, status_word[7:2], 2'b00});
		@(posedge ref_clk);
		#2 wp_n = 1'b1;
		wr_sr(8'h01, 8'h00);
		wr_sr(8'h31, 8'h03);
		wr_sr(8'h01, 8'h04);
		chk(24'h000300, {status_word[23:2], 2'b00});
		@(posedge ref_clk);
		#2 rst = 1'b1;
		repeat (4) @(posedge ref_clk);
		#2 rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(24'h000200, status_word);
		end_sim();
	end
endmodule : serial_flash_command_and_protection_tb
`default_nettype wire
